// *** rtl/fp_operand_format_unit.v ***
`timescale 1ns/1ps
`include "fp_operand_format_regs.vh"


module fp_operand_format_unit (
	input  wire        clock_i,
	input  wire        rst_i,
	input  wire        issue_i,
	input  wire [2:0]  op_i,
	input  wire [2:0]  fmt_i,
	input  wire        src_is_fpreg_i,
	input  wire [63:0] rf_port_a_i,
	input  wire [63:0] rf_port_b_i,
	input  wire [63:0] ext_operand_i,
	input  wire [31:0] cache_ctrl_reg_i,
	input  wire        ide_enable_i,
	input  wire [2:0]  ea_mode_i,
	input  wire [2:0]  ea_reg_i,
	input  wire [31:0] ea_base_i,
	input  wire [15:0] ea_disp_i,
	output reg         done_o,
	output reg         result_final_o,
	output reg  [63:0] result_o,
	output reg  [63:0] opnd_a_o,
	output reg  [63:0] opnd_b_o,
	output reg         res_neg_o,
	output reg         res_zero_o,
	output reg         res_inf_o,
	output reg         res_nan_o,
	output reg         exc_inan_o,
	output reg         exc_operr_o,
	output reg         exc_ovfl_o,
	output reg         exc_ide_o,
	output reg         unimpl_trap_o,
	output reg  [7:0]  trap_vector_o,
	output reg         ea_error_o,
	output reg         mem_read_o,
	output reg  [31:0] mem_addr_o,
	output reg         areg_write_o,
	output reg  [31:0] areg_value_o
);

	// ------------------------------------------------------------
	// Trap gating
	// ------------------------------------------------------------
	wire fpu_disable_bit;
	wire run;
	wire dyadic;

	// Nothing is executed while disabled, the kernel sees only the trap
	assign fpu_disable_bit = cache_ctrl_reg_i[`FPU_DISABLE_BIT];
	assign run             = issue_i & ~fpu_disable_bit;
	assign dyadic          = (op_i != `OP_MOVE);

	// ------------------------------------------------------------
	// Integer source conversion
	// ------------------------------------------------------------
	reg  [31:0] int_ext;
	reg  [31:0] int_mag;
	reg  [4:0]  int_msb;
	reg  [31:0] int_shift;
	reg  [63:0] int_dbl;
	integer     i;

	// Sign extension as the integer unit does; conversion is exact
	always @* begin
		int_ext   = 32'h0;
		int_mag   = 32'h0;
		int_msb   = 5'h0;
		int_shift = 32'h0;
		int_dbl   = 64'h0;
		if (fmt_i == `FMT_BYTE) begin
			int_ext = {{24{ext_operand_i[7]}}, ext_operand_i[7:0]};
		end else if (fmt_i == `FMT_WORD) begin
			int_ext = {{16{ext_operand_i[15]}}, ext_operand_i[15:0]};
		end else begin
			int_ext = ext_operand_i[31:0];
		end
		int_mag = int_ext[31] ? (~int_ext + 32'h1) : int_ext;
		for (i = 0; i < 32; i = i + 1) begin
			if (int_mag[i]) begin
				int_msb = i[4:0];
			end
		end
		int_shift = int_mag << (`INT_TOP_POS - int_msb);
		if (int_mag == 32'h0) begin
			int_dbl = 64'h0;
		end else begin
			int_dbl = {int_ext[31], `DBL_BIAS + {6'h0, int_msb},
				int_shift[30:0], `INT_FRAC_PAD};
		end
	end

	// ------------------------------------------------------------
	// Data type decode
	// ------------------------------------------------------------
	wire sg_sign, sg_inf, sg_nan, sg_norm;
	wire a_sign, a_zero, a_den, a_inf, a_nan, a_norm;
	wire b_sign, b_zero, b_den, b_inf, b_nan, b_norm;

	// Single source straight from the operand bus
	fp_operand_classify #(.EXP_W(`SGL_EXP_W), .FRAC_W(`SGL_FRAC_W)) u_class_sgl (
		.value_i     (ext_operand_i[`SGL_SIGN:0]),
		.sign_o      (sg_sign),
		.is_zero_o   (),
		.is_denorm_o (),
		.is_inf_o    (sg_inf),
		.is_nan_o    (sg_nan),
		.is_norm_o   (sg_norm),
		.int_bit_o   ()
	);

	// Single widened: rebias exponent, pad fraction on the right
	reg [63:0] sgl_dbl;
	always @* begin
		sgl_dbl = 64'h0;
		if (sg_norm) begin
			sgl_dbl = {sg_sign, {3'h0, ext_operand_i[30:23]} + `SGL_TO_DBL_BIAS,
				ext_operand_i[22:0], `SGL_FRAC_PAD};
		end else if (sg_inf | sg_nan) begin
			sgl_dbl = {sg_sign, `DBL_EXP_MAX, ext_operand_i[22:0], `SGL_FRAC_PAD};
		end else begin
			// Denormal kept as such so the double decode still flags it
			sgl_dbl = {sg_sign, `DBL_EXP_ZERO, ext_operand_i[22:0], `SGL_FRAC_PAD};
		end
	end

	// Source operand B: register file port B or converted external
	reg [63:0] src_b_dbl;
	always @* begin
		if (src_is_fpreg_i) begin
			src_b_dbl = rf_port_b_i;
		end else if (fmt_i == `FMT_DOUBLE) begin
			src_b_dbl = ext_operand_i;
		end else if (fmt_i == `FMT_SINGLE) begin
			src_b_dbl = sgl_dbl;
		end else begin
			src_b_dbl = int_dbl;
		end
	end

	fp_operand_classify #(.EXP_W(`DBL_EXP_W), .FRAC_W(`DBL_FRAC_W)) u_class_a (
		.value_i     (rf_port_a_i),
		.sign_o      (a_sign),
		.is_zero_o   (a_zero),
		.is_denorm_o (a_den),
		.is_inf_o    (a_inf),
		.is_nan_o    (a_nan),
		.is_norm_o   (a_norm),
		.int_bit_o   ()
	);

	fp_operand_classify #(.EXP_W(`DBL_EXP_W), .FRAC_W(`DBL_FRAC_W)) u_class_b (
		.value_i     (src_b_dbl),
		.sign_o      (b_sign),
		.is_zero_o   (b_zero),
		.is_denorm_o (b_den),
		.is_inf_o    (b_inf),
		.is_nan_o    (b_nan),
		.is_norm_o   (b_norm),
		.int_bit_o   ()
	);

	// ------------------------------------------------------------
	// Denormal flush
	// ------------------------------------------------------------
	wire        den_a;
	wire        den_b;
	wire        den_trap;
	wire [63:0] opa_flush;
	wire [63:0] opb_flush;
	wire        za;
	wire        zb;

	// No denormal arithmetic here: flush or hand to the software trap
	assign den_a     = dyadic & a_den;
	assign den_b     = b_den;
	assign den_trap  = ide_enable_i & (den_a | den_b);
	assign opa_flush = a_den ? {a_sign, 63'h0} : rf_port_a_i;
	assign opb_flush = b_den ? {b_sign, 63'h0} : src_b_dbl;
	assign za        = a_zero | a_den;
	assign zb        = b_zero | b_den;

	// ------------------------------------------------------------
	// Special results and overflow
	// ------------------------------------------------------------
	reg  [12:0] exp_est;
	reg         ovfl;
	reg         operr;
	wire        any_nan;
	wire [12:0] ea_w;
	wire [12:0] eb_w;

	assign any_nan = b_nan | (dyadic & a_nan);
	assign ea_w    = {2'h0, rf_port_a_i[62:52]};
	assign eb_w    = {2'h0, src_b_dbl[62:52]};

	// Unbounded exponent before rounding, normal operands only
	always @* begin
		exp_est = 13'h0;
		operr   = 1'b0;
		ovfl    = 1'b0;
		case (op_i)
			`OP_ADD: begin
				exp_est = ((ea_w > eb_w) ? ea_w : eb_w) + `EXP_CALC_ONE;
				operr   = a_inf & b_inf & (a_sign != b_sign);
			end
			`OP_SUB: begin
				exp_est = ((ea_w > eb_w) ? ea_w : eb_w) + `EXP_CALC_ONE;
				operr   = a_inf & b_inf & (a_sign == b_sign);
			end
			`OP_MUL: begin
				exp_est = ea_w + eb_w - `EXP_CALC_BIAS;
				operr   = (a_inf & zb) | (za & b_inf);
			end
			`OP_DIV: begin
				exp_est = ea_w - eb_w + `EXP_CALC_BIAS;
				operr   = (a_inf & b_inf) | (za & zb);
			end
			default: begin
				exp_est = 13'h0;
				operr   = 1'b0;
			end
		endcase
		if (dyadic & a_norm & b_norm) begin
			ovfl = ($signed(exp_est) >= $signed(`EXP_CALC_MAX));
		end
	end

	// ------------------------------------------------------------
	// Result selection
	// ------------------------------------------------------------
	reg  [63:0] res;
	reg         res_final;

	// Default NaN is never a copy of an input payload
	always @* begin
		res       = opb_flush;
		res_final = 1'b0;
		if (den_trap) begin
			res       = opb_flush;
			res_final = 1'b0;
		end else if (any_nan | operr) begin
			res       = `DEFAULT_NAN;
			res_final = 1'b1;
		end else if (ovfl) begin
			res       = {a_sign ^ (b_sign & (op_i == `OP_MUL || op_i == `OP_DIV)),
				`DBL_EXP_MAX, 52'h0};
			res_final = 1'b1;
		end else if (!dyadic) begin
			res       = opb_flush;
			res_final = 1'b1;
		end
	end

	// ------------------------------------------------------------
	// Operand addressing
	// ------------------------------------------------------------
	reg  [31:0] step;
	reg  [31:0] addr;
	reg  [31:0] areg_nxt;
	reg         areg_wr;
	reg         mem_rd;
	reg         ea_bad;
	wire [31:0] disp_ext;

	assign disp_ext = {{16{ea_disp_i[15]}}, ea_disp_i};

	// Register direct is refused for double: it cannot fit a register
	always @* begin
		step     = `STEP_LONG;
		addr     = ea_base_i;
		areg_nxt = ea_base_i;
		areg_wr  = 1'b0;
		mem_rd   = 1'b0;
		ea_bad   = 1'b0;
		if (fmt_i == `FMT_BYTE) begin
			step = `STEP_BYTE;
		end else if (fmt_i == `FMT_WORD) begin
			step = `STEP_WORD;
		end else if (fmt_i == `FMT_DOUBLE) begin
			step = `STEP_DOUBLE;
		end
		if (src_is_fpreg_i) begin
			ea_bad = 1'b0;
		end else if (ea_mode_i == `EA_DATA_REG || ea_mode_i == `EA_ADDR_REG) begin
			ea_bad = (fmt_i == `FMT_DOUBLE);
		end else if (ea_mode_i == `EA_INDIRECT) begin
			mem_rd = 1'b1;
		end else if (ea_mode_i == `EA_POSTINC) begin
			mem_rd   = 1'b1;
			areg_nxt = ea_base_i + step;
			areg_wr  = 1'b1;
		end else if (ea_mode_i == `EA_PREDEC) begin
			mem_rd   = 1'b1;
			addr     = ea_base_i - step;
			areg_nxt = ea_base_i - step;
			areg_wr  = 1'b1;
		end else if (ea_mode_i == `EA_DISP16 ||
			(ea_mode_i == `EA_EXTENDED && ea_reg_i == `EA_REG_PC_DISP)) begin
			mem_rd = 1'b1;
			addr   = ea_base_i + disp_ext;
		end else begin
			ea_bad = 1'b1;
		end
	end

	// ------------------------------------------------------------
	// Output stage
	// ------------------------------------------------------------
	wire go;
	assign go = run & ~ea_bad;

	// One registered stage; status and exception flags are single-cycle pulses, the res_* class flags hold until the next go
	always @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			done_o         <= 1'b0;
			result_final_o <= 1'b0;
			result_o       <= 64'h0;
			opnd_a_o       <= 64'h0;
			opnd_b_o       <= 64'h0;
			res_neg_o      <= 1'b0;
			res_zero_o     <= 1'b0;
			res_inf_o      <= 1'b0;
			res_nan_o      <= 1'b0;
			exc_inan_o     <= 1'b0;
			exc_operr_o    <= 1'b0;
			exc_ovfl_o     <= 1'b0;
			exc_ide_o      <= 1'b0;
			unimpl_trap_o  <= 1'b0;
			trap_vector_o  <= 8'h00;
			ea_error_o     <= 1'b0;
			mem_read_o     <= 1'b0;
			mem_addr_o     <= 32'h0;
			areg_write_o   <= 1'b0;
			areg_value_o   <= 32'h0;
		end else begin
			done_o         <= go;
			result_final_o <= go & res_final;
			exc_inan_o     <= go & any_nan & ~den_trap;
			exc_operr_o    <= go & operr & ~any_nan & ~den_trap;
			exc_ovfl_o     <= go & ovfl & ~any_nan & ~operr & ~den_trap;
			exc_ide_o      <= go & den_trap;
			unimpl_trap_o  <= issue_i & fpu_disable_bit;
			ea_error_o     <= run & ea_bad;
			mem_read_o     <= go & mem_rd;
			areg_write_o   <= go & areg_wr;
			if (issue_i & fpu_disable_bit) begin
				trap_vector_o <= `UNIMPL_VECTOR;
			end
			if (go) begin
				result_o     <= res;
				opnd_a_o     <= opa_flush;
				opnd_b_o     <= opb_flush;
				res_neg_o    <= res[`DBL_SIGN] & ~(&res[62:52] & |res[51:0]);
				res_zero_o   <= ~|res[62:0];
				res_inf_o    <= &res[62:52] & ~|res[51:0];
				res_nan_o    <= &res[62:52] & |res[51:0];
				mem_addr_o   <= addr;
				areg_value_o <= areg_nxt;
			end
		end
	end

endmodule

// *** common/fp_operand_format_regs.vh ***
`ifndef FP_OPERAND_FORMAT_REGS_VH
`define FP_OPERAND_FORMAT_REGS_VH

// ----------------------------------------------------------------
// Disable control and trap
// ----------------------------------------------------------------
`define FPU_DISABLE_BIT   4
`define UNIMPL_VECTOR     8'h0b

// ----------------------------------------------------------------
// Format field layout
// ----------------------------------------------------------------
`define SGL_EXP_W         8
`define SGL_FRAC_W        23
`define SGL_SIGN          31
`define DBL_EXP_W         11
`define DBL_FRAC_W        52
`define DBL_SIGN          63
`define SGL_FRAC_PAD      29'h0
`define INT_FRAC_PAD      21'h0

// ----------------------------------------------------------------
// Exponent constants
// ----------------------------------------------------------------
`define DBL_BIAS          11'h3ff
`define SGL_TO_DBL_BIAS   11'h380
`define DBL_EXP_MAX       11'h7ff
`define DBL_EXP_ZERO      11'h000
`define EXP_CALC_BIAS     13'h03ff
`define EXP_CALC_MAX      13'h07ff
`define EXP_CALC_ONE      13'h0001
`define DEFAULT_NAN       64'h7fff_ffff_ffff_ffff
`define INT_TOP_POS       5'h1f

// ----------------------------------------------------------------
// Source formats
// ----------------------------------------------------------------
`define FMT_LONG          3'h0
`define FMT_SINGLE        3'h1
`define FMT_WORD          3'h4
`define FMT_DOUBLE        3'h5
`define FMT_BYTE          3'h6

// ----------------------------------------------------------------
// Operations
// ----------------------------------------------------------------
`define OP_MOVE           3'h0
`define OP_ADD            3'h1
`define OP_SUB            3'h2
`define OP_MUL            3'h3
`define OP_DIV            3'h4

// ----------------------------------------------------------------
// Operand source modes
// ----------------------------------------------------------------
`define EA_DATA_REG       3'h0
`define EA_ADDR_REG       3'h1
`define EA_INDIRECT       3'h2
`define EA_POSTINC        3'h3
`define EA_PREDEC         3'h4
`define EA_DISP16         3'h5
`define EA_EXTENDED       3'h7
`define EA_REG_PC_DISP    3'h2
`define STEP_BYTE         32'h0000_0001
`define STEP_WORD         32'h0000_0002
`define STEP_LONG         32'h0000_0004
`define STEP_DOUBLE       32'h0000_0008

`endif

// *** rtl/fp_operand_classify.v ***
`timescale 1ns/1ps

// ----------------------------------------------------------------
// Data type decode of one IEEE operand
// ----------------------------------------------------------------
module fp_operand_classify #(
	parameter EXP_W  = 11,
	parameter FRAC_W = 52
) (
	input  wire [EXP_W+FRAC_W:0] value_i,
	output wire                  sign_o,
	output wire                  is_zero_o,
	output wire                  is_denorm_o,
	output wire                  is_inf_o,
	output wire                  is_nan_o,
	output wire                  is_norm_o,
	output wire                  int_bit_o
);

	wire [EXP_W-1:0]  exp_field;
	wire [FRAC_W-1:0] frac_field;
	wire              exp_min;
	wire              exp_top;
	wire              frac_nil;

	// Field split, sign always in the top bit
	assign sign_o     = value_i[EXP_W+FRAC_W];
	assign exp_field  = value_i[EXP_W+FRAC_W-1:FRAC_W];
	assign frac_field = value_i[FRAC_W-1:0];
	assign exp_min    = ~|exp_field;
	assign exp_top    = &exp_field;
	assign frac_nil   = ~|frac_field;

	// Five exclusive data types
	assign is_norm_o   = ~exp_min & ~exp_top;
	assign is_denorm_o = exp_min & ~frac_nil;
	assign is_zero_o   = exp_min & frac_nil;
	assign is_inf_o    = exp_top & frac_nil;
	assign is_nan_o    = exp_top & ~frac_nil;

	// Hidden bit; meaningless for NaN, so forced low there
	assign int_bit_o   = is_norm_o | is_inf_o;

endmodule

// *** tb/fp_operand_format_checker.sv ***
`timescale 1ns/1ps

// ----------------------------------------------------------------
// Port checks of the operand format unit
// ----------------------------------------------------------------
module fp_operand_format_checker (
	input wire        clock_i,
	input wire        rst_i,
	input wire        issue_i,
	input wire        src_is_fpreg_i,
	input wire [2:0]  ea_mode_i,
	input wire [31:0] cache_ctrl_reg_i,
	input wire        done_o,
	input wire        result_final_o,
	input wire [63:0] result_o,
	input wire [63:0] opnd_b_o,
	input wire        res_zero_o,
	input wire        res_inf_o,
	input wire        res_nan_o,
	input wire        exc_inan_o,
	input wire        exc_operr_o,
	input wire        exc_ovfl_o,
	input wire        exc_ide_o,
	input wire        unimpl_trap_o,
	input wire [7:0]  trap_vector_o,
	input wire        ea_error_o
);
	default clocking @(posedge clock_i); endclocking
	default disable iff (rst_i);

	// Trap request and its lone answer
	sequence s_trap_req;
		issue_i && cache_ctrl_reg_i[4];
	endsequence
	sequence s_trap_ans;
		unimpl_trap_o && !done_o && !ea_error_o && trap_vector_o == 8'h0b;
	endsequence
	// Final answers, whose class flags must match the value
	sequence s_final;
		done_o && result_final_o;
	endsequence

	chk_trap_taken: assert property (s_trap_req |=> s_trap_ans)
		else $error("disabled unit did not trap");
	chk_exec_enabled: assert property (issue_i && !cache_ctrl_reg_i[4] |=>
		!unimpl_trap_o && (done_o || ea_error_o)) else $error("enabled issue unanswered");
	chk_no_spurious: assert property (!issue_i |=>
		!(done_o || unimpl_trap_o || ea_error_o)) else $error("answer without issue");
	chk_nan_default: assert property (done_o && exc_inan_o |->
		result_final_o && result_o == 64'h7fff_ffff_ffff_ffff) else $error("nan input kept");
	chk_nan_pattern: assert property (s_final ##0 res_nan_o |->
		result_o == 64'h7fff_ffff_ffff_ffff) else $error("generated nan pattern");
	chk_operr_nan: assert property (done_o && exc_operr_o |->
		result_final_o && res_nan_o) else $error("operand error without nan");
	chk_inf_class: assert property (s_final |->
		res_inf_o == (result_o[62:0] == {11'h7ff, 52'h0})) else $error("infinity class");
	chk_zero_class: assert property (s_final |->
		res_zero_o == (result_o[62:0] == 63'h0)) else $error("zero class");
	chk_ovfl_inf: assert property (done_o && exc_ovfl_o |->
		res_inf_o && result_final_o) else $error("overflow not infinity");
	chk_flush_zero: assert property (done_o && !exc_ide_o && opnd_b_o[62:52] == 11'h0 |->
		opnd_b_o[51:0] == 52'h0) else $error("denormal not flushed");
	chk_ide_defer: assert property (done_o && exc_ide_o |-> !result_final_o)
		else $error("denormal trap with final result");
	chk_ea_refuse: assert property (issue_i && !cache_ctrl_reg_i[4] &&
		!src_is_fpreg_i && ea_mode_i == 3'h6 |=> ea_error_o && !done_o)
		else $error("illegal mode accepted");
endmodule

bind fp_operand_format_unit fp_operand_format_checker i_chk (
	.clock_i, .rst_i, .issue_i, .src_is_fpreg_i, .ea_mode_i, .cache_ctrl_reg_i, .done_o,
	.result_final_o, .result_o, .opnd_b_o, .res_zero_o, .res_inf_o, .res_nan_o, .exc_inan_o,
	.exc_operr_o, .exc_ovfl_o, .exc_ide_o, .unimpl_trap_o, .trap_vector_o, .ea_error_o
);

// *** tb/fp_regfile_model.sv ***
`timescale 1ns/1ps

// ----------------------------------------------------------------
// Dual-ported floating-point register file
// ----------------------------------------------------------------
module fp_regfile_model (
	input  wire        clock_i,
	input  wire        wr_i,
	input  wire [2:0]  wr_idx_i,
	input  wire [63:0] wr_data_i,
	input  wire [2:0]  rd_a_i,
	input  wire [2:0]  rd_b_i,
	output wire [63:0] port_a_o,
	output wire [63:0] port_b_o
);
	logic [63:0] reg_ff [0:7];

	// Write port, holds doubles only
	always @(posedge clock_i) begin
		if (wr_i) begin
			reg_ff[wr_idx_i] <= wr_data_i;
		end
	end

	// Two independent read ports, no wait states
	assign port_a_o = reg_ff[rd_a_i];
	assign port_b_o = reg_ff[rd_b_i];
endmodule

// *** tb/tb.sv ***
`timescale 1ns/1ps
`include "fp_operand_format_regs.vh"

module tb;
	typedef struct {
		logic [2:0]  k;
		logic        fin;
		logic [3:0]  x;
		logic [63:0] r;
		logic        cr;
		logic        ca;
		logic [31:0] ad;
		logic [31:0] av;
		logic        oc;
		logic [63:0] oa;
	} expt;

	logic        clock_i, rst_i, issue_i, src_is_fpreg_i, ide_enable_i, rf_wr, ide;
	logic [2:0]  op_i, fmt_i, ea_mode_i, ea_reg_i, rd_a, rd_b, rf_idx, er, f;
	logic [15:0] ea_disp_i, dsp;
	logic [31:0] cache_ctrl_reg_i, ea_base_i, ccr, seed, v, sv;
	logic [63:0] ext_operand_i, rf_data;
	wire  [63:0] rf_port_a_i, rf_port_b_i, result_o, opnd_a_o, opnd_b_o;
	wire  [31:0] mem_addr_o, areg_value_o;
	wire  [7:0]  trap_vector_o;
	wire         done_o, result_final_o, res_neg_o, res_zero_o, res_inf_o, res_nan_o;
	wire         exc_inan_o, exc_operr_o, exc_ovfl_o, exc_ide_o, unimpl_trap_o, ea_error_o;
	wire         mem_read_o, areg_write_o;
	int          fails, compares;
	expt         q[$];
	expt         me;
	logic [63:0] dtab[10] = '{64'h0, 64'h8000_0000_0000_0000, 64'h7ff0_0000_0000_0000,
		64'hfff0_0000_0000_0000, 64'h7ff8_0000_0000_0000, 64'hfff0_0000_0000_0001, 64'h1,
		64'h800f_ffff_ffff_ffff, 64'h7fef_ffff_ffff_ffff, 64'h0010_0000_0000_0000};
	logic [63:0] rtab[8] = '{64'hfe70_0000_0000_0000, 64'h7e70_0000_0000_0000,
		64'h5ff0_0000_0000_0000, 64'h5fe0_0000_0000_0000, 64'h7ff0_0000_0000_0000,
		64'hfff0_0000_0000_0000, 64'h8000_0000_0000_0001, 64'hfff0_0000_0000_0001};

	fp_operand_format_unit i_dut (.clock_i, .rst_i, .issue_i, .op_i, .fmt_i, .src_is_fpreg_i,
		.rf_port_a_i, .rf_port_b_i, .ext_operand_i, .cache_ctrl_reg_i, .ide_enable_i, .ea_mode_i,
		.ea_reg_i, .ea_base_i, .ea_disp_i, .done_o, .result_final_o, .result_o, .opnd_a_o,
		.opnd_b_o, .res_neg_o, .res_zero_o, .res_inf_o, .res_nan_o, .exc_inan_o, .exc_operr_o,
		.exc_ovfl_o, .exc_ide_o, .unimpl_trap_o, .trap_vector_o, .ea_error_o, .mem_read_o,
		.mem_addr_o, .areg_write_o, .areg_value_o);
	fp_regfile_model i_rf (.clock_i, .wr_i(rf_wr), .wr_idx_i(rf_idx), .wr_data_i(rf_data),
		.rd_a_i(rd_a), .rd_b_i(rd_b), .port_a_o(rf_port_a_i), .port_b_o(rf_port_b_i));

	// ----------------------------------------------------------------
	// Reference conversions
	// ----------------------------------------------------------------
	function automatic expt ex(logic [2:0] k, logic fin, logic [3:0] x, logic [63:0] r,
		logic cr);
		ex = '{k, fin, x, r, cr, 1'b0, 32'h0, 32'h0, 1'b0, 64'h0};
	endfunction
	function automatic expt mv(logic [63:0] r);
		mv = ex(3'h4, 1'b1, {r === `DEFAULT_NAN, 3'h0}, r, 1'b1);
	endfunction
	function automatic logic [63:0] i2d(logic [31:0] s);
		logic [31:0] m;
		int          p;
		if (s == 32'h0) return 64'h0;
		m = s[31] ? -s : s;
		p = 31;
		while (!m[p]) p--;
		return {s[31], 11'h3ff + 11'(p), 52'(64'(m) << (52 - p))};
	endfunction
	function automatic logic [63:0] f2d(logic [31:0] s);
		if (s[30:23] == 8'h00) return {s[31], 63'h0};
		if (s[30:23] == 8'hff) return s[22:0] != 23'h0 ? `DEFAULT_NAN : {s[31], 11'h7ff, 52'h0};
		return {s[31], 11'(s[30:23]) + 11'h380, s[22:0], 29'h0};
	endfunction
	function automatic logic [63:0] d2d(logic [63:0] d);
		if (d[62:52] == 11'h0) return {d[63], 63'h0};
		if (d[62:52] == 11'h7ff && d[51:0] != 52'h0) return `DEFAULT_NAN;
		return d;
	endfunction
	function automatic logic [3:0] cls(logic [63:0] r);
		logic n;
		n = r[62:52] == 11'h7ff && r[51:0] != 52'h0;
		return {r[63] & !n, r[62:0] == 63'h0, r[62:0] == {11'h7ff, 52'h0}, n};
	endfunction

	// ----------------------------------------------------------------
	// Driver and comparison tasks
	// ----------------------------------------------------------------
	task automatic chk(string n, logic [63:0] s, logic [63:0] e);
		compares++;
		if (s !== e) begin
			fails++;
			$display("MISMATCH %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic go(logic [2:0] o, logic [2:0] fm, logic fp, logic [63:0] x, logic [2:0] m,
		logic [31:0] b, expt ee);
		@(posedge clock_i);
		issue_i <= 1'b1;
		op_i <= o;
		fmt_i <= fm;
		src_is_fpreg_i <= fp;
		ext_operand_i <= x;
		rd_a <= x[2:0];
		rd_b <= x[5:3];
		ea_mode_i <= m;
		ea_reg_i <= er;
		ea_base_i <= b;
		ea_disp_i <= dsp;
		cache_ctrl_reg_i <= ccr;
		ide_enable_i <= ide;
		q.push_back(ee);
	endtask
	task automatic dy(logic [2:0] o, logic [2:0] a, logic [2:0] b, expt ee);
		ee.oc = 1'b1;
		ee.oa = rtab[a][62:52] == 11'h0 ? {rtab[a][63], 63'h0} : rtab[a];
		go(o, 3'h0, 1'b1, {58'h0, b, a}, 3'h0, 32'h0, ee);
	endtask
	task automatic tend(string s);
		@(posedge clock_i);
		issue_i <= 1'b0;
		repeat (3) @(posedge clock_i);
		$display("test %s done", s);
	endtask
	function automatic expt ea(logic [31:0] ad, logic [31:0] av);
		ea = mv(i2d(32'h5));
		ea.ca = 1'b1;
		ea.ad = ad;
		ea.av = av;
	endfunction
	task automatic final_report();
		$display("compares %0d fails %0d", compares, fails);
		if (fails == 0 && compares > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	// ----------------------------------------------------------------
	// Clock, monitor and watchdog
	// ----------------------------------------------------------------
	initial begin
		clock_i = 1'b0;
		forever #2.5 clock_i = ~clock_i;
	end

	// Oldest note is matched against each answer, mid-cycle when settled
	always @(negedge clock_i) begin
		if (!rst_i && (done_o || unimpl_trap_o || ea_error_o)) begin
			me = q.size() != 0 ? q.pop_front() : ex(3'h0, 1'b0, 4'h0, 64'h0, 1'b0);
			chk("answer", {done_o, unimpl_trap_o, ea_error_o}, me.k);
			if (me.k == 3'h2) chk("vector", trap_vector_o, 8'h0b);
			if (me.k == 3'h4) begin
				chk("final", result_final_o, me.fin);
				chk("exc", {exc_inan_o, exc_operr_o, exc_ovfl_o, exc_ide_o}, me.x);
			end
			if (me.cr) begin
				chk("result", result_o, me.r);
				chk("class", {res_neg_o, res_zero_o, res_inf_o, res_nan_o}, cls(me.r));
			end
			if (me.oc) chk("opnd_a", opnd_a_o, me.oa);
			if (me.ca) begin
				chk("addr", {mem_read_o, mem_addr_o}, {1'b1, me.ad});
				chk("areg", areg_write_o ? areg_value_o : 32'h0, me.av);
			end
		end
	end

	// Whole run is about 125 cycles
	initial begin
		repeat (3000) @(posedge clock_i);
		fails++;
		final_report();
	end

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		{rst_i, seed, ccr, ide, dsp, er} = {1'b1, 32'hd90a1a0b, 52'h0};
		{issue_i, op_i, fmt_i, src_is_fpreg_i, ext_operand_i, ide_enable_i} = 73'h0;
		{ea_mode_i, ea_reg_i, ea_base_i, ea_disp_i, cache_ctrl_reg_i} = 86'h0;
		{rf_wr, rf_idx, rf_data, rd_a, rd_b} = 74'h0;
		repeat (8) @(posedge clock_i);
		rst_i <= 1'b0;
		for (int i = 0; i < 8; i++) begin
			@(posedge clock_i);
			{rf_wr, rf_idx, rf_data} <= {1'b1, 3'(i), rtab[i]};
		end
		@(posedge clock_i);
		rf_wr <= 1'b0;
		// Signed integers, sign extended from each width, back to back
		for (int i = 0; i < 24; i++) begin
			v = i == 0 ? 32'hffff_8080 : i == 1 ? 32'h0 : $random(seed);
			f = i % 3 == 0 ? `FMT_BYTE : i % 3 == 1 ? `FMT_WORD : `FMT_LONG;
			sv = f == `FMT_BYTE ? {{24{v[7]}}, v[7:0]} : f == `FMT_WORD ? {{16{v[15]}}, v[15:0]} : v;
			go(`OP_MOVE, f, 1'b0, {32'h0, v}, `EA_DATA_REG, 32'h0, mv(i2d(sv)));
		end
		tend("integers");
		// Singles and doubles, single infinity and double special encodings first
		for (int i = 0; i < 20; i++) begin
			v = i < 4 ? (32'h7f80_0000 << i) | 32'(i == 1) : $random(seed);
			go(`OP_MOVE, `FMT_SINGLE, 1'b0, {$random(seed), v}, 3'h0, 32'h0, mv(f2d(v)));
			rf_data = i < 10 ? dtab[i] : {$random(seed), $random(seed)};
			go(`OP_MOVE, `FMT_DOUBLE, 1'b0, rf_data, `EA_INDIRECT, 32'h40, mv(d2d(rf_data)));
		end
		ide = 1'b1;
		go(`OP_MOVE, `FMT_DOUBLE, 1'b0, 64'h1, `EA_INDIRECT, 32'h40, ex(3'h4, 0, 4'h1, 0, 0));
		ide = 1'b0;
		tend("formats");
		// Dyadic specials from the register file
		dy(`OP_MUL, 3'h0, 3'h1, ex(3'h4, 1, 4'h2, 64'hfff0_0000_0000_0000, 1));
		dy(`OP_MUL, 3'h2, 3'h2, ex(3'h4, 1, 4'h2, 64'h7ff0_0000_0000_0000, 1));
		dy(`OP_MUL, 3'h2, 3'h3, ex(3'h4, 0, 4'h0, 64'h0, 0));
		dy(`OP_DIV, 3'h4, 3'h4, ex(3'h4, 1, 4'h4, `DEFAULT_NAN, 1));
		dy(`OP_ADD, 3'h4, 3'h5, ex(3'h4, 1, 4'h4, `DEFAULT_NAN, 1));
		dy(`OP_SUB, 3'h4, 3'h4, ex(3'h4, 1, 4'h4, `DEFAULT_NAN, 1));
		dy(`OP_MUL, 3'h4, 3'h6, ex(3'h4, 1, 4'h4, `DEFAULT_NAN, 1));
		dy(`OP_DIV, 3'h6, 3'h6, ex(3'h4, 1, 4'h4, `DEFAULT_NAN, 1));
		dy(`OP_ADD, 3'h7, 3'h1, ex(3'h4, 1, 4'h8, `DEFAULT_NAN, 1));
		tend("dyadic");
		// Disable bit traps, neighbouring bits do not
		ccr = 32'h10;
		go(`OP_MOVE, `FMT_LONG, 1'b0, 64'h5, 3'h0, 32'h0, ex(3'h2, 0, 4'h0, 0, 0));
		go(`OP_ADD, `FMT_LONG, 1'b0, 64'h5, 3'h0, 32'h0, ex(3'h2, 0, 4'h0, 0, 0));
		ccr = 32'hffff_ffef;
		go(`OP_MOVE, `FMT_LONG, 1'b0, 64'h5, 3'h0, 32'h0, mv(i2d(32'h5)));
		ccr = 32'h0;
		tend("disable");
		// Memory operand modes and refused modes
		dsp = 16'hfff0;
		go(`OP_MOVE, `FMT_LONG, 1'b0, 64'h5, `EA_ADDR_REG, 32'h100, mv(i2d(32'h5)));
		go(`OP_MOVE, `FMT_LONG, 1'b0, 64'h5, `EA_INDIRECT, 32'h100, ea(32'h100, 0));
		go(`OP_MOVE, `FMT_LONG, 1'b0, 64'h5, `EA_POSTINC, 32'h100, ea(32'h100, 32'h104));
		go(`OP_MOVE, `FMT_LONG, 1'b0, 64'h5, `EA_PREDEC, 32'h100, ea(32'hfc, 32'hfc));
		go(`OP_MOVE, `FMT_LONG, 1'b0, 64'h5, `EA_DISP16, 32'h100, ea(32'hf0, 0));
		go(`OP_MOVE, `FMT_LONG, 1'b0, 64'h5, 3'h6, 32'h100, ex(3'h1, 0, 4'h0, 0, 0));
		go(`OP_MOVE, `FMT_DOUBLE, 1'b0, 64'h5, 3'h0, 32'h100, ex(3'h1, 0, 4'h0, 0, 0));
		er = 3'h2;
		go(`OP_MOVE, `FMT_LONG, 1'b0, 64'h5, `EA_EXTENDED, 32'h100, ea(32'hf0, 0));
		er = 3'h0;
		go(`OP_MOVE, `FMT_LONG, 1'b0, 64'h5, `EA_EXTENDED, 32'h100, ex(3'h1, 0, 4'h0, 0, 0));
		tend("modes");
		chk("pending", 64'(q.size()), 64'h0);
		final_report();
	end
endmodule
